// [core/scbk_bank.sv]
// sync control register bank: serial slave, sync muxes, coast, formatter
// assumes pixel data and pixel clock share core_clk_i; pins are asynchronous
// Summary of operation
// - with vsync override set, select bit picks vsync pin (0) or separator (1)
// - coast select passes coast pin (0) or the selected vsync (1)
// - power-down bit low powers both interfaces down; resets to one
// - activity detection is frozen while fully powered down
// - separator counts threshold clocks at a new level before following it
// - scan enable lets output registers shift serially via scan pins
// - coast polarity override picks user instead of detected polarity
// - line sync polarity override picks user instead of detected polarity
// - status bit 7 shows detected line sync polarity
// - status bit 6 shows detected vertical sync polarity
// - status bit 5 shows detected coast input polarity
// - five-bit green slicer threshold field, default code 23
// - coast starts the lead count of lines before vertical sync
// - coast stays the trail count of lines after vertical sync
// - format bit switches pixel output between 4:4:4 and 4:2:2
// - in 4:2:2 green carries luma, red alternates chroma, blue floats
// - without override, vsync pin is chosen whenever its activity is seen
// - serial port auto-increments to 1dh and refuses base addresses above
`timescale 1ns/1ns
`default_nettype none
module scbk_bank #(
  parameter int PIX_W = 8,
  parameter int LINE_W = 12
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic [1:0] dev_addr_i,
  input wire logic vsync_pin_i,
  input wire logic coast_pin_i,
  input wire logic hsync_i,
  input wire logic green_channel_sync_i,
  input wire logic vsync_activity_i,
  input wire logic green_activity_i,
  input wire logic hsync_pol_i,
  input wire logic vsync_pol_i,
  input wire logic coast_pol_i,
  input wire logic scan_clk_i,
  input wire logic scan_in_i,
  input wire logic [PIX_W-1:0] red_i,
  input wire logic [PIX_W-1:0] green_i,
  input wire logic [PIX_W-1:0] blue_i,
  output logic full_power_down_n_o,
  output logic vsync_sel_o,
  output logic coast_o,
  output logic coast_pol_ovr_o,
  output logic hsync_pol_ovr_o,
  output logic [4:0] green_slicer_code_o,
  output logic scan_out_o,
  output logic [PIX_W-1:0] red_o,
  output logic [PIX_W-1:0] green_o,
  output logic [PIX_W-1:0] blue_o,
  output logic blue_oe_o
);
  // ==========================================================
  // parameter checks
  initial begin
    if (PIX_W < 2 || LINE_W < 9) begin
      $error("scbk_bank: PIX_W must be >= 2 and LINE_W >= 9");
    end
  end

  // ==========================================================
  // input synchronisers
  localparam int NS = 13;
  logic [NS-1:0] sync1;
  logic [NS-1:0] sync2;
  logic [NS-1:0] sync_q;
  // two flops per pin, plus one delayed copy for edges
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      sync1 <= 13'h0003;
      sync2 <= 13'h0003;
      sync_q <= 13'h0003;
    end else begin
      sync1 <= {scan_in_i, scan_clk_i, coast_pol_i, vsync_pol_i, hsync_pol_i,
        green_activity_i, vsync_activity_i, green_channel_sync_i, hsync_i,
        coast_pin_i, vsync_pin_i, sda_i, scl_i};
      sync2 <= sync1;
      sync_q <= sync2;
    end
  end
  logic scl, sda, vs_pin, co_pin, hs, csync, vs_act, gr_act;
  logic hpol, vpol, cpol, scan_clk, scan_in;
  assign {scan_in, scan_clk, cpol, vpol, hpol, gr_act, vs_act, csync, hs,
    co_pin, vs_pin, sda, scl} = sync2;
  // address straps pass the same two flops as the other pins
  logic [1:0] addr_s1;
  logic [1:0] addr_s2;
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      addr_s1 <= 2'h0;
      addr_s2 <= 2'h0;
    end else begin
      addr_s1 <= dev_addr_i;
      addr_s2 <= addr_s1;
    end
  end
  logic scl_rise, scl_fall, start, stop, scan_edge;
  assign scl_rise = scl & ~sync_q[0];
  assign scl_fall = ~scl & sync_q[0];
  assign start = scl & sync_q[0] & sync_q[1] & ~sda;
  assign stop = scl & sync_q[0] & ~sync_q[1] & sda;
  assign scan_edge = scan_clk & ~sync_q[11];

  // ==========================================================
  // register storage
  logic [7:0] regs [scbk_pkg::REG_COUNT];
  logic [7:0] stat;
  logic wr_stb;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;

  // read decode, shared by address ack and read ack
  function automatic logic [7:0] rd_byte(input logic [7:0] a);
    logic [3:0] idx;
    idx = 4'(a - scbk_pkg::OFF_SRC_PWR);
    if (a < scbk_pkg::OFF_SRC_PWR || a > scbk_pkg::OFF_FMT) begin
      rd_byte = 8'h00;
    end else if (a == scbk_pkg::OFF_STATUS) begin
      rd_byte = stat;
    end else begin
      rd_byte = regs[idx];
    end
  endfunction
  // byte at the pointer, ready for the next read transfer
  logic [7:0] rd_now;
  always_comb begin
    rd_now = rd_byte(ptr);
  end

  for (genvar g = 0; g < scbk_pkg::REG_COUNT; g++) begin : g_reg
    always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
        regs[g] <= scbk_pkg::RST_TABLE[g];
      end else if (wr_stb && wr_addr == 8'(scbk_pkg::OFF_SRC_PWR + g)
          && wr_addr != scbk_pkg::OFF_STATUS) begin
        regs[g] <= wr_data;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      stat <= 8'h00;
    end else begin
      stat <= 8'h00;
      stat[scbk_pkg::F_HS_POL] <= hpol;
      stat[scbk_pkg::F_VS_POL] <= vpol;
      stat[scbk_pkg::F_COAST_POL] <= cpol;
    end
  end

  logic [7:0] r_src, r_pol;
  assign r_src = regs[0];
  assign r_pol = regs[2];
  assign full_power_down_n_o = r_src[scbk_pkg::F_PWR_N];
  assign coast_pol_ovr_o = r_pol[scbk_pkg::F_COAST_POL_OVR];
  assign hsync_pol_ovr_o = r_pol[scbk_pkg::F_HS_POL_OVR];
  assign sda_o = 1'b0;

  // ==========================================================
  // serial slave
  scbk_pkg::scbk_port_t st;
  logic [7:0] sh;
  logic [7:0] ptr;
  logic [2:0] bcnt;
  logic rw, ack_ph;
  logic [7:0] ptr_inc;
  assign ptr_inc = (ptr >= scbk_pkg::ADDR_MAX) ? ptr : ptr + 8'h01;

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      st <= scbk_pkg::S_IDLE;
      sh <= 8'h00;
      ptr <= 8'h00;
      bcnt <= 3'h0;
      rw <= 1'b0;
      ack_ph <= 1'b0;
      sda_oe_o <= 1'b0;
      wr_stb <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
    end else begin
      wr_stb <= 1'b0;
      if (start) begin
        st <= scbk_pkg::S_DEV;
        bcnt <= 3'h0;
        ack_ph <= 1'b0;
        sda_oe_o <= 1'b0;
      end else if (stop) begin
        st <= scbk_pkg::S_IDLE;
        sda_oe_o <= 1'b0;
      end else begin
        case (st)
          scbk_pkg::S_DEV, scbk_pkg::S_REG, scbk_pkg::S_WR: begin
            if (scl_rise) begin
              sh <= {sh[6:0], sda};
              bcnt <= bcnt + 3'h1;
              if (bcnt == 3'h7) begin
                ack_ph <= 1'b0;
                if (st == scbk_pkg::S_DEV) begin
                  st <= scbk_pkg::S_DEV_ACK;
                end else if (st == scbk_pkg::S_REG) begin
                  st <= scbk_pkg::S_REG_ACK;
                end else begin
                  wr_stb <= 1'b1;
                  wr_addr <= ptr;
                  wr_data <= {sh[6:0], sda};
                  ptr <= ptr_inc;
                  st <= scbk_pkg::S_WR_ACK;
                end
              end
            end
          end
          scbk_pkg::S_DEV_ACK: begin
            if (scl_fall && !ack_ph) begin
              if (sh[7:1] == {scbk_pkg::DEV_ADDR_HI, addr_s2}) begin
                sda_oe_o <= 1'b1;
                ack_ph <= 1'b1;
                rw <= sh[0];
              end else begin
                st <= scbk_pkg::S_IGNORE;
              end
            end else if (scl_fall) begin
              bcnt <= 3'h0;
              if (rw) begin
                sh <= rd_now;
                sda_oe_o <= ~rd_now[7];
                st <= scbk_pkg::S_RD;
              end else begin
                sda_oe_o <= 1'b0;
                st <= scbk_pkg::S_REG;
              end
            end
          end
          scbk_pkg::S_REG_ACK: begin
            if (scl_fall && !ack_ph) begin
              if (sh <= scbk_pkg::ADDR_MAX) begin
                ptr <= sh;
                sda_oe_o <= 1'b1;
                ack_ph <= 1'b1;
              end else begin
                st <= scbk_pkg::S_IGNORE;
              end
            end else if (scl_fall) begin
              sda_oe_o <= 1'b0;
              st <= scbk_pkg::S_WR;
            end
          end
          scbk_pkg::S_WR_ACK: begin
            if (scl_fall && !ack_ph) begin
              sda_oe_o <= 1'b1;
              ack_ph <= 1'b1;
            end else if (scl_fall) begin
              sda_oe_o <= 1'b0;
              st <= scbk_pkg::S_WR;
            end
          end
          scbk_pkg::S_RD: begin
            if (scl_fall) begin
              if (bcnt == 3'h7) begin
                sda_oe_o <= 1'b0;
                ptr <= ptr_inc;
                st <= scbk_pkg::S_RD_ACK;
              end else begin
                sh <= {sh[6:0], 1'b0};
                sda_oe_o <= ~sh[6];
                bcnt <= bcnt + 3'h1;
              end
            end
          end
          scbk_pkg::S_RD_ACK: begin
            // master nack ends the read
            if (scl_rise) begin
              ack_ph <= ~sda;
            end else if (scl_fall && ack_ph) begin
              sh <= rd_now;
              sda_oe_o <= ~rd_now[7];
              bcnt <= 3'h0;
              st <= scbk_pkg::S_RD;
            end else if (scl_fall) begin
              st <= scbk_pkg::S_IGNORE;
            end
          end
          default: begin
            sda_oe_o <= 1'b0;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // activity capture, sync separator, vsync select
  logic vs_seen, sep_out;
  logic [7:0] sep_cnt;
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      vs_seen <= 1'b0;
    end else if (full_power_down_n_o) begin
      vs_seen <= vs_act | (gr_act & 1'b0);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      sep_out <= 1'b0;
      sep_cnt <= 8'h00;
    end else if (csync == sep_out) begin
      sep_cnt <= 8'h00;
    end else if (sep_cnt >= regs[1]) begin
      sep_out <= csync;
      sep_cnt <= 8'h00;
    end else begin
      sep_cnt <= sep_cnt + 8'h01;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      vsync_sel_o <= 1'b0;
    end else if (r_src[scbk_pkg::F_VS_OVR]) begin
      vsync_sel_o <= r_src[scbk_pkg::F_VS_SEL];
    end else begin
      vsync_sel_o <= ~vs_seen;
    end
  end

  assign green_slicer_code_o = regs[4][7:scbk_pkg::F_GREEN_LSB];

  // ==========================================================
  // coast generation
  logic vs_n, vs_nq, hs_n, hs_nq, co_n;
  logic [LINE_W-1:0] line_cnt, frame_len;
  logic [7:0] post_cnt;
  logic pre_act;
  assign hs_n = hs ~^ (hpol | hsync_pol_ovr_o);
  assign co_n = co_pin ~^ (cpol | coast_pol_ovr_o);
  assign vs_n = (vsync_sel_o ? sep_out : vs_pin) ~^ vpol;
  assign pre_act = (frame_len != '0) &&
    ({1'b0, line_cnt} + (LINE_W + 1)'(regs[5]) >= {1'b0, frame_len});

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      vs_nq <= 1'b0;
      hs_nq <= 1'b0;
      line_cnt <= '0;
      frame_len <= '0;
      post_cnt <= 8'h00;
    end else begin
      vs_nq <= vs_n;
      hs_nq <= hs_n;
      if (vs_n && !vs_nq) begin
        frame_len <= line_cnt;
        line_cnt <= '0;
      end else if (hs_n && !hs_nq && line_cnt != '1) begin
        line_cnt <= line_cnt + 1'b1;
      end
      if (!vs_n && vs_nq) begin
        post_cnt <= regs[6];
      end else if (hs_n && !hs_nq && post_cnt != 8'h00) begin
        post_cnt <= post_cnt - 8'h01;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      coast_o <= 1'b0;
    end else if (r_src[scbk_pkg::F_COAST_SEL]) begin
      coast_o <= vs_n | pre_act | (post_cnt != 8'h00);
    end else begin
      coast_o <= co_n;
    end
  end

  // ==========================================================
  // output formatter and scan chain
  logic fmt422, scan_en, uv_ph;
  assign fmt422 = regs[10][scbk_pkg::F_FMT_422];
  assign scan_en = r_pol[scbk_pkg::F_SCAN_EN];
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      red_o <= '0;
      green_o <= '0;
      blue_o <= '0;
      blue_oe_o <= 1'b0;
      uv_ph <= 1'b0;
      scan_out_o <= 1'b0;
    end else if (scan_en) begin
      if (scan_edge) begin
        {red_o, green_o, blue_o} <= {red_o[PIX_W-2:0], green_o, blue_o, scan_in};
        scan_out_o <= red_o[PIX_W-1];
      end
    end else if (!full_power_down_n_o) begin
      red_o <= '0;
      green_o <= '0;
      blue_o <= '0;
      blue_oe_o <= 1'b0;
    end else begin
      green_o <= green_i;
      uv_ph <= fmt422 & ~uv_ph;
      red_o <= (fmt422 && uv_ph) ? blue_i : red_i;
      blue_o <= fmt422 ? '0 : blue_i;
      blue_oe_o <= ~fmt422;
    end
  end

  // ==========================================================
  // checks
  sequence s_vs_end;
    !vs_n && vs_nq;
  endsequence
  sequence s_wr_done;
    wr_stb && wr_addr >= scbk_pkg::OFF_SRC_PWR && wr_addr <= scbk_pkg::OFF_FMT
      && wr_addr != scbk_pkg::OFF_STATUS;
  endsequence

  a_pwr_reset_val: assert property (@(posedge core_clk_i)
    $past(sys_rst_i) && !sys_rst_i |-> full_power_down_n_o
      && green_slicer_code_o == 5'h17)
    else $error("power or slicer default wrong after reset");
  a_vsync_ovr_sel: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    r_src[scbk_pkg::F_VS_OVR] |=> vsync_sel_o == $past(r_src[scbk_pkg::F_VS_SEL]))
    else $error("vsync override select not followed");
  a_vsync_auto_pin: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !r_src[scbk_pkg::F_VS_OVR] && vs_seen |=> !vsync_sel_o)
    else $error("vsync pin not chosen while active");
  a_coast_pin_pass: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !r_src[scbk_pkg::F_COAST_SEL] |=> coast_o == $past(co_n))
    else $error("coast pin not passed");
  a_detect_frozen: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !full_power_down_n_o |=> $stable(vs_seen))
    else $error("activity changed in power-down");
  a_sep_level_hold: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    $changed(sep_out) |-> $past(sep_cnt) >= $past(regs[1]))
    else $error("separator toggled before threshold");
  a_readback_write: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    s_wr_done |=> rd_byte($past(wr_addr)) == $past(wr_data))
    else $error("written register does not read back");
  a_ptr_saturate: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    ptr <= scbk_pkg::ADDR_MAX)
    else $error("register pointer past limit");
  a_post_coast_load: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    s_vs_end |=> post_cnt == $past(regs[6]) ##1 r_src[scbk_pkg::F_COAST_SEL]
      && post_cnt != 8'h00 |-> coast_o)
    else $error("trail coast not held");
  a_blue_float_422: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    fmt422 && !scan_en && full_power_down_n_o |=> !blue_oe_o && green_o == $past(green_i))
    else $error("4:2:2 output packing wrong");
  a_scan_shift_in: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    scan_en && scan_edge |=> blue_o[0] == $past(scan_in))
    else $error("scan input not shifted in");
endmodule
`default_nettype wire

// [core/scbk_pkg.sv]
// constants shared by the sync control register bank
// assumes one core clock; all offsets are serial-port register addresses
package scbk_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] OFF_SRC_PWR = 8'h12;
  localparam logic [7:0] OFF_SEP_THR = 8'h13;
  localparam logic [7:0] OFF_SCAN_POL = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h15;
  localparam logic [7:0] OFF_GREEN_THR = 8'h16;
  localparam logic [7:0] OFF_LEAD = 8'h17;
  localparam logic [7:0] OFF_TRAIL = 8'h18;
  localparam logic [7:0] OFF_TEST_A = 8'h19;
  localparam logic [7:0] OFF_TEST_B = 8'h1a;
  localparam logic [7:0] OFF_TEST_C = 8'h1b;
  localparam logic [7:0] OFF_FMT = 8'h1c;
  localparam logic [7:0] ADDR_MAX = 8'h1d;
  localparam int REG_COUNT = 11;
  // ==========================================================
  // reset values
  localparam logic [7:0] RST_SRC_PWR = 8'h01;
  localparam logic [7:0] RST_SEP_THR = 8'h20;
  localparam logic [7:0] RST_SCAN_POL = 8'h00;
  localparam logic [7:0] RST_GREEN_THR = 8'hb8;
  localparam logic [7:0] RST_LEAD = 8'h00;
  localparam logic [7:0] RST_TRAIL = 8'h00;
  localparam logic [7:0] RST_TEST_A = 8'h00;
  localparam logic [7:0] RST_TEST_B = 8'h00;
  localparam logic [7:0] RST_TEST_C = 8'h00;
  localparam logic [7:0] RST_FMT = 8'h00;
  localparam logic [7:0] RST_TABLE [REG_COUNT] = '{RST_SRC_PWR, RST_SEP_THR,
    RST_SCAN_POL, 8'h00, RST_GREEN_THR, RST_LEAD, RST_TRAIL, RST_TEST_A,
    RST_TEST_B, RST_TEST_C, RST_FMT};
  // ==========================================================
  // field positions
  localparam int F_VS_OVR = 3;
  localparam int F_VS_SEL = 2;
  localparam int F_COAST_SEL = 1;
  localparam int F_PWR_N = 0;
  localparam int F_SCAN_EN = 2;
  localparam int F_COAST_POL_OVR = 1;
  localparam int F_HS_POL_OVR = 0;
  localparam int F_HS_POL = 7;
  localparam int F_VS_POL = 6;
  localparam int F_COAST_POL = 5;
  localparam int F_GREEN_LSB = 3;
  localparam int F_FMT_422 = 1;
  // ==========================================================
  // serial port
  localparam logic [4:0] DEV_ADDR_HI = 5'h13;
  typedef enum {S_IDLE, S_DEV, S_DEV_ACK, S_REG, S_REG_ACK, S_WR, S_WR_ACK,
    S_RD, S_RD_ACK, S_IGNORE} scbk_port_t;
endpackage

// [test/scbk_host.sv]
// 2-wire host model: drives scl, pulls sda low, reads the wired sda
// assumes an external pull-up, so a released sda reads high
`timescale 1ns/1ns
`default_nettype none
module scbk_host (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  localparam int HALF = 6;
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // ==========================================================
  // bit level
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // one scl pulse: level 1 releases sda; returns sda seen while scl high
  task automatic clk_bit(input logic lvl, output logic seen);
    sda_low_o <= ~lvl;
    wait_n(HALF);
    scl_o <= 1'b1;
    wait_n(HALF);
    seen = sda_i;
    scl_o <= 1'b0;
    wait_n(1);
  endtask
  // start also serves as repeated start from scl low
  task automatic start_cond();
    wait_n(1);
    sda_low_o <= 1'b0;
    wait_n(HALF);
    scl_o <= 1'b1;
    wait_n(HALF);
    sda_low_o <= 1'b1;
    wait_n(HALF);
    scl_o <= 1'b0;
    wait_n(HALF);
  endtask
  task automatic stop_cond();
    sda_low_o <= 1'b1;
    wait_n(HALF);
    scl_o <= 1'b1;
    wait_n(HALF);
    sda_low_o <= 1'b0;
    wait_n(HALF);
  endtask
  // ==========================================================
  // byte level, msb first
  task automatic put_byte(input logic [7:0] b, output logic ack_o);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
    clk_bit(1'b1, s);
    ack_o = ~s;
  endtask
  // last byte is answered with a nack to end the read
  task automatic get_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, s);
      b[i] = s;
    end
    clk_bit(last, s);
  endtask
  task automatic write_regs(input logic [6:0] dev, input logic [7:0] base,
      input logic [7:0] d [$], output logic ok);
    logic a;
    start_cond();
    put_byte({dev, 1'b0}, ok);
    put_byte(base, a);
    ok = ok & a;
    foreach (d[i]) begin
      put_byte(d[i], a);
      ok = ok & a;
    end
    stop_cond();
  endtask
  task automatic read_regs(input logic [6:0] dev, input logic [7:0] base, input int n,
      output logic [7:0] q [$], output logic ok);
    logic a;
    logic [7:0] b;
    start_cond();
    put_byte({dev, 1'b0}, ok);
    put_byte(base, a);
    ok = ok & a;
    start_cond();
    put_byte({dev, 1'b1}, a);
    ok = ok & a;
    q = {};
    for (int i = 0; i < n; i++) begin
      get_byte(i == n - 1, b);
      q.push_back(b);
    end
    stop_cond();
  endtask
endmodule
`default_nettype wire

// [test/sync_control_register_bank_tb.sv]
// testbench for the sync control register bank over its 2-wire port
// assumes the host model in scbk_host.sv and a pull-up on sda
`timescale 1ns/1ns
`default_nettype none
module sync_control_register_bank_tb;
  localparam logic [6:0] DEV = {scbk_pkg::DEV_ADDR_HI, 2'b10};
  localparam logic [3:0] CT [4] = '{4'b0101, 4'b0010, 4'b1101, 4'b1010};
  logic core_clk_i, sys_rst_i, vsync_pin_i, coast_pin_i, hsync_i;
  logic green_channel_sync_i, vsync_activity_i, green_activity_i;
  logic hsync_pol_i, vsync_pol_i, coast_pol_i, scan_clk_i, scan_in_i;
  logic [1:0] dev_addr_i;
  logic [7:0] red_i, green_i, blue_i, red_o, green_o, blue_o, r0;
  logic sda_o, sda_oe_o, full_power_down_n_o, vsync_sel_o, coast_o;
  logic coast_pol_ovr_o, hsync_pol_ovr_o, scan_out_o, blue_oe_o;
  logic [4:0] green_slicer_code_o;
  wire scl_i;
  wire sda_low;
  wire sda_i = ~(sda_low | sda_oe_o);
  int num_errors = 0;
  int total_checks = 0;
  scbk_host host (.clk_i(core_clk_i), .sda_i(sda_i), .scl_o(scl_i), .sda_low_o(sda_low));
  scbk_bank DUT (.core_clk_i, .sys_rst_i, .scl_i, .sda_i, .sda_o, .sda_oe_o, .dev_addr_i,
    .vsync_pin_i, .coast_pin_i, .hsync_i, .green_channel_sync_i, .vsync_activity_i,
    .green_activity_i, .hsync_pol_i, .vsync_pol_i, .coast_pol_i, .scan_clk_i, .scan_in_i,
    .red_i, .green_i, .blue_i, .full_power_down_n_o, .vsync_sel_o, .coast_o,
    .coast_pol_ovr_o, .hsync_pol_ovr_o, .green_slicer_code_o, .scan_out_o, .red_o,
    .green_o, .blue_o, .blue_oe_o);
  initial begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end
  // ==========================================================
  // helpers
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic nap(input int n);
    repeat (n) @(posedge core_clk_i);
    @(negedge core_clk_i);
  endtask
  task automatic wr(input logic [6:0] dev, input logic [7:0] base, input logic [7:0] d [$],
      input logic exp_ack);
    logic ok;
    host.write_regs(dev, base, d, ok);
    chk("write_ack", {7'h0, exp_ack}, {7'h0, ok});
    nap(4);
  endtask
  task automatic rd(input logic [7:0] base, input int n, output logic [7:0] q [$]);
    logic ok;
    host.read_regs(DEV, base, n, q, ok);
    chk("read_ack", 8'h01, {7'h0, ok});
    nap(4);
  endtask
  // watchdog well beyond the expected run
  initial begin
    repeat (60000) @(posedge core_clk_i);
    num_errors++;
    wrap_up();
  end
  // ==========================================================
  // main sequence
  initial begin
    logic [7:0] q [$];
    {sys_rst_i, vsync_activity_i, hsync_pol_i, coast_pol_i} = 4'hf;
    {vsync_pin_i, coast_pin_i, hsync_i, green_channel_sync_i, green_activity_i} = 5'h00;
    {vsync_pol_i, scan_clk_i, scan_in_i} = 3'h0;
    dev_addr_i = 2'b10;
    {red_i, green_i, blue_i} = {8'h81, 8'h42, 8'h24};
    repeat (6) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    nap(3);
    chk("pwr_n", 8'h01, {7'h0, full_power_down_n_o});
    chk("slicer", 8'h17, {3'h0, green_slicer_code_o});
    chk("pol_ovr", 8'h00, {6'h0, coast_pol_ovr_o, hsync_pol_ovr_o});
    rd(8'h12, scbk_pkg::REG_COUNT, q);
    for (int i = 0; i < scbk_pkg::REG_COUNT; i++)
      chk("reset_reg", (i == 3) ? 8'ha0 : scbk_pkg::RST_TABLE[i], q[i]);
    wr(DEV, 8'h15, '{8'h5f}, 1'b1);
    rd(8'h15, 1, q);
    chk("status", 8'ha0, q[0]);
    wr(DEV, 8'h1e, '{8'h11}, 1'b0);
    wr({scbk_pkg::DEV_ADDR_HI, 2'b01}, 8'h13, '{8'h11}, 1'b0);
    wr(DEV, 8'h1a, '{8'h41, 8'h10, 8'hbc, 8'h77, 8'h77}, 1'b1);
    rd(8'h1a, 4, q);
    foreach (q[i]) chk("burst", (i == 0) ? 8'h41 : (i == 1) ? 8'h10 : (i == 2) ? 8'hbc : 8'h00, q[i]);
    @(posedge core_clk_i);
    vsync_activity_i <= 1'b0;
    nap(8);
    chk("auto_sep", 8'h01, {7'h0, vsync_sel_o});
    @(posedge core_clk_i);
    vsync_activity_i <= 1'b1;
    nap(8);
    chk("auto_pin", 8'h00, {7'h0, vsync_sel_o});
    wr(DEV, 8'h12, '{8'h00}, 1'b1);
    chk("pwr_down", 8'h00, {7'h0, full_power_down_n_o});
    @(posedge core_clk_i);
    vsync_activity_i <= 1'b0;
    nap(8);
    chk("frozen", 8'h00, {7'h0, vsync_sel_o});
    for (int v = 0; v < 2; v++) begin
      @(posedge core_clk_i);
      vsync_activity_i <= v[0];
      wr(DEV, 8'h12, '{{5'h01, v[0], 2'b01}}, 1'b1);
      chk("vs_ovr", {7'h0, v[0]}, {7'h0, vsync_sel_o});
    end
    for (int i = 0; i < 4; i++) begin
      wr(DEV, 8'h12, '{{6'h02, CT[i][3], 1'b1}}, 1'b1);
      @(posedge core_clk_i);
      coast_pin_i <= CT[i][2];
      vsync_pin_i <= CT[i][1];
      nap(8);
      chk("coast", {7'h0, CT[i][0]}, {7'h0, coast_o});
    end
    // separator: a pulse below threshold is filtered, a long one passes
    wr(DEV, 8'h12, '{8'h0f}, 1'b1);
    for (int n = 20; n <= 60; n += 40) begin
      @(posedge core_clk_i);
      green_channel_sync_i <= 1'b1;
      repeat (n) @(posedge core_clk_i);
      green_channel_sync_i <= 1'b0;
      nap(8);
      chk("separator", {7'h0, n == 20}, {7'h0, coast_o});
    end
    wr(DEV, 8'h12, '{8'h0b}, 1'b1);
    wr(DEV, 8'h18, '{8'h02}, 1'b1);
    for (int v = 0; v < 2; v++) begin
      @(posedge core_clk_i);
      vsync_pin_i <= v[0];
      nap(8);
    end
    // coast holds two line edges after vsync ends
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk_i);
      hsync_i <= ~i[0];
      nap(4);
      if (i[0]) chk("post_coast", {7'h0, i == 1}, {7'h0, coast_o});
    end
    wr(DEV, 8'h16, '{8'hff}, 1'b1);
    chk("slicer", 8'h1f, {3'h0, green_slicer_code_o});
    wr(DEV, 8'h14, '{8'h03}, 1'b1);
    chk("pol_ovr", 8'h03, {6'h0, coast_pol_ovr_o, hsync_pol_ovr_o});
    chk("red444", 8'h81, red_o);
    chk("blue444", 8'h25, {blue_o[7:1], blue_oe_o});
    wr(DEV, 8'h1c, '{8'hbe}, 1'b1);
    r0 = red_o;
    nap(0);
    chk("red422", 8'h81 ^ 8'h24, r0 ^ red_o);
    chk("green422", 8'h42, green_o);
    chk("blue422", 8'h00, {blue_o[7:1], blue_oe_o});
    wr(DEV, 8'h1c, '{8'hbc}, 1'b1);
    wr(DEV, 8'h14, '{8'h04}, 1'b1);
    @(posedge core_clk_i);
    scan_in_i <= 1'b1;
    scan_clk_i <= 1'b1;
    repeat (6) @(posedge core_clk_i);
    scan_clk_i <= 1'b0;
    nap(6);
    chk("scan_out", 8'h01, {7'h0, scan_out_o});
    chk("scan_red", 8'h02, red_o);
    chk("scan_blue", 8'h49, blue_o);
    chk("scan_green", 8'h84, green_o);
    chk("sda_o", 8'h00, {7'h0, sda_o});
    wrap_up();
  end
endmodule
`default_nettype wire
